//--- pta_activation.sv
// Purpose: card side protocol activation (RATS, ATS, PPS) behind an AXI4-Lite register port
// Assumes: received frames arrive byte by byte with end of frame and crc result; one clock
// Notes: ATS bytes are streamed from software-set fields; select/field reset come as flags from below, halt is decoded from a frame
// Functional notes
// - answer RATS only directly after selection
// - card answers PPS request with PPS response
// - RATS is E0, parameter, two crc
// - parameter upper nibble is reader frame code
// - frame code maps to 16..256 bytes
// - card latches identifier of first good RATS
// - absent ATS fields take default values
// - ATS order: length, format, TA, TB, TC, history
// - length counts itself, at most FSD minus two
// - format byte present when length exceeds one
// - format bit8 zero, bits7..5 flag TC TB TA
// - format low nibble card frame code, default 2
// - TA bit8 set forbids split divisors
// - TA send/receive rates, bit4 zero, default 000
// - TB wait integer 0..14, default 4
// - after ATS ignore further RATS and other blocks
// - PPS start D plus identifier, echoed back
`timescale 1ns/1ns
`default_nettype none
`include "pta_regs.svh"
module pta_activation #(
  parameter int HIST_MAX = 4 // historical bytes sent from the hist register
) (
  input wire logic clk_sys_in, // 10 MHz system clock
  input wire logic rst_in, // async reset, active high
  // axi4-lite slave
  input wire logic [7:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [7:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  // frame layer below
  input wire logic sel_done_in, // one-cycle pulse: selection completed
  input wire logic field_reset_in, // one-cycle pulse: field lost or power-up
  input wire logic rx_valid_in, // received byte strobe
  input wire logic [7:0] rx_byte_in,
  input wire logic rx_eof_in, // end of frame pulse, after last byte
  input wire logic rx_crc_ok_in, // crc result, valid with rx_eof_in
  input wire logic tx_ready_in, // transmitter takes tx byte
  output logic tx_valid_out,
  output logic [7:0] tx_byte_out,
  output logic tx_last_out, // marks last byte of frame, crc appended below
  output logic [3:0] cid_out, // latched card identifier
  output logic active_out // card in active step or waiting for PPS, low while the PPS echo is sent
);
  import pta_pkg::*;

  pta_state_t state_reg; // activation step
  logic [31:0] ctrl_reg; // bit0 enable, bit1 pps supported
  logic [31:0] ats_reg; // [7:0] format, [15:8] TA, [23:16] TB, [31:24] TC
  logic [31:0] hist_reg; // up to four historical bytes
  logic [3:0] fsdi_reg; // reader frame code from RATS
  logic [3:0] cid_reg; // identifier from first good RATS
  logic [7:0] pps_start_reg; // start byte to echo
  logic [1:0] rx_cnt_reg; // byte count in current frame
  logic [7:0] rx_b0_reg; // first byte of frame
  logic [7:0] rx_b1_reg; // second byte
  logic [4:0] tx_idx_reg; // byte position in ATS
  logic [7:0] ats_byte [0:8]; // candidate ATS bytes
  logic [8:0] ats_keep; // which candidates are sent
  logic [3:0] tx_len; // number of bytes in ATS
  logic [8:0] fsd_bytes; // reader frame size
  logic [2:0] hist_n; // historical bytes sent
  logic [7:0] fmt; // format byte with reserved bit cleared
  logic good_eof; // error-free frame ended
  logic is_rats;
  logic is_pps;

  assign good_eof = rx_eof_in && rx_crc_ok_in;
  assign is_rats = good_eof && rx_cnt_reg == 2'd2 && rx_b0_reg == `PTA_RATS_CODE;
  assign is_pps = good_eof && rx_b0_reg[7:4] == `PTA_PPS_NIB && rx_b0_reg[3:0] == cid_reg;

  // reader frame size from code; reserved codes treated as 256
  always_comb begin
    case (fsdi_reg)
      4'h0: fsd_bytes = 9'd16;
      4'h1: fsd_bytes = 9'd24;
      4'h2: fsd_bytes = 9'd32;
      4'h3: fsd_bytes = 9'd40;
      4'h4: fsd_bytes = 9'd48;
      4'h5: fsd_bytes = 9'd64;
      4'h6: fsd_bytes = 9'd96;
      4'h7: fsd_bytes = 9'd128;
      default: fsd_bytes = 9'd256;
    endcase
  end

  // ATS assembly: TA, TB and TC present only when flagged in the format byte
  always_comb begin
    fmt = {1'b0, ats_reg[6:0]};
    hist_n = 3'(HIST_MAX);
    ats_keep = {{HIST_MAX{1'b1}}, fmt[`PTA_T0_TC], fmt[`PTA_T0_TB], fmt[`PTA_T0_TA], 1'b1, 1'b1};
    // trim history so the frame plus crc never passes FSD
    if (fsd_bytes < 9'd16) begin
      hist_n = 3'd0;
    end
    ats_byte[0] = 8'h00;
    ats_byte[1] = fmt;
    ats_byte[2] = {ats_reg[15:12], 1'b0, ats_reg[10:8]};
    ats_byte[3] = ats_reg[23:16];
    ats_byte[4] = ats_reg[31:24];
    for (int i = 0; i < 4; i++) begin
      ats_byte[5 + i] = hist_reg[8*i +: 8];
    end
    tx_len = 4'd2 + 4'(fmt[`PTA_T0_TA]) + 4'(fmt[`PTA_T0_TB]) + 4'(fmt[`PTA_T0_TC])
      + 4'(hist_n);
    ats_byte[0] = {4'h0, tx_len};
    ats_keep[8:5] = 4'hf >> (3'd4 - hist_n);
  end

  // receive byte capture
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      rx_cnt_reg <= 2'd0;
      rx_b0_reg <= 8'h00;
      rx_b1_reg <= 8'h00;
    end else if (rx_eof_in) begin
      rx_cnt_reg <= 2'd0;
    end else if (rx_valid_in) begin
      if (rx_cnt_reg == 2'd0) begin
        rx_b0_reg <= rx_byte_in;
      end else if (rx_cnt_reg == 2'd1) begin
        rx_b1_reg <= rx_byte_in;
      end
      if (rx_cnt_reg != 2'd3) begin
        rx_cnt_reg <= rx_cnt_reg + 2'd1;
      end
    end
  end

  // activation state machine
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= PTA_IDLE;
      fsdi_reg <= `PTA_FSCI_DEF;
      cid_reg <= 4'h0;
      pps_start_reg <= 8'h00;
    end else if (field_reset_in || !ctrl_reg[0]) begin
      state_reg <= PTA_IDLE;
    end else if (sel_done_in) begin
      state_reg <= PTA_SELECTED;
    end else begin
      case (state_reg)
        PTA_SELECTED: begin
          // only the first command after selection is answered
          if (is_rats) begin
            fsdi_reg <= rx_b1_reg[7:4];
            cid_reg <= rx_b1_reg[3:0];
            state_reg <= PTA_ATS_SEND;
          end else if (good_eof && rx_b0_reg == `PTA_HALT_CODE) begin
            state_reg <= PTA_HALTED;
          end else if (good_eof) begin
            // other blocks get no answer; a good one closes the RATS window
            state_reg <= PTA_IDLE;
          end
          // a frame with a bad crc counts as not received and changes nothing
        end
        PTA_ATS_SEND: begin
          if (tx_ready_in && tx_last_out) begin
            state_reg <= ctrl_reg[1] ? PTA_PPS_WAIT : PTA_ACTIVE;
          end
        end
        PTA_PPS_WAIT: begin
          if (is_pps) begin
            pps_start_reg <= rx_b0_reg;
            state_reg <= PTA_PPS_SEND;
          end else if (rx_eof_in) begin
            state_reg <= PTA_ACTIVE; // any other frame closes the PPS window
          end
        end
        PTA_PPS_SEND: begin
          // leave only once the echo byte has really been taken
          if (tx_valid_out && tx_ready_in) begin
            state_reg <= PTA_ACTIVE;
          end
        end
        PTA_IDLE, PTA_ACTIVE, PTA_HALTED: begin
          state_reg <= state_reg; // RATS no longer answered
        end
        default: state_reg <= PTA_IDLE;
      endcase
    end
  end

  // transmit stream: ATS bytes in order, then the PPS echo
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      tx_valid_out <= 1'b0;
      tx_byte_out <= 8'h00;
      tx_last_out <= 1'b0;
      tx_idx_reg <= 5'd0;
    end else if (state_reg == PTA_ATS_SEND && !(tx_valid_out && tx_ready_in && tx_last_out)) begin
      if (!tx_valid_out || tx_ready_in) begin
        // skip positions whose presence flag is clear
        logic [4:0] nx;
        logic [3:0] sent;
        nx = tx_valid_out ? tx_idx_reg + 5'd1 : 5'd0;
        sent = 4'd0;
        while (nx < 5'd9 && !ats_keep[nx[3:0]]) begin
          nx = nx + 5'd1;
        end
        for (int j = 0; j < 9; j++) begin
          if (5'(j) > nx && ats_keep[j]) begin
            sent = sent + 4'd1;
          end
        end
        tx_idx_reg <= nx;
        tx_byte_out <= ats_byte[nx[3:0]];
        tx_valid_out <= 1'b1;
        tx_last_out <= sent == 4'd0;
      end
    end else if (state_reg == PTA_PPS_SEND) begin
      tx_byte_out <= pps_start_reg;
      tx_valid_out <= !(tx_valid_out && tx_ready_in);
      tx_last_out <= 1'b1;
    end else begin
      tx_valid_out <= 1'b0;
      tx_last_out <= 1'b0;
    end
  end

  // status outputs
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      cid_out <= 4'h0;
      active_out <= 1'b0;
    end else begin
      cid_out <= cid_reg;
      active_out <= state_reg == PTA_ACTIVE || state_reg == PTA_PPS_WAIT;
    end
  end

  // axi write channel: address and data in either order, response after both
  logic aw_held_reg;
  logic w_held_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      aw_held_reg <= 1'b0;
      w_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out <= 1'b0;
      s_axi_bvalid_out <= 1'b0;
      s_axi_bresp_out <= 2'b00;
      ctrl_reg <= `PTA_CTRL_RST;
      ats_reg <= `PTA_ATS_RST;
      hist_reg <= 32'h0;
    end else begin
      s_axi_awready_out <= !aw_held_reg && !s_axi_awready_out && !s_axi_bvalid_out;
      s_axi_wready_out <= !w_held_reg && !s_axi_wready_out && !s_axi_bvalid_out;
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata_in;
        w_strb_reg <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (aw_held_reg && w_held_reg && !s_axi_bvalid_out) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out <= 2'b00;
        for (int b = 0; b < 4; b++) begin
          if (w_strb_reg[b]) begin
            case (aw_addr_reg)
              `PTA_CTRL_OFF: ctrl_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
              `PTA_ATS_OFF: ats_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
              `PTA_HIST_OFF: hist_reg[8*b +: 8] <= w_data_reg[8*b +: 8];
              default: ;
            endcase
          end
        end
        if (aw_addr_reg != `PTA_CTRL_OFF && aw_addr_reg != `PTA_ATS_OFF
            && aw_addr_reg != `PTA_HIST_OFF && aw_addr_reg != `PTA_STAT_OFF) begin
          s_axi_bresp_out <= 2'b10; // unmapped: slave error
        end
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out <= 1'b0;
      end
    end
  end

  // axi read channel: data one cycle after address is taken
  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out <= 1'b0;
      s_axi_rdata_out <= 32'h0;
      s_axi_rresp_out <= 2'b00;
    end else begin
      s_axi_arready_out <= !s_axi_arready_out && !s_axi_rvalid_out;
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out <= 1'b1;
        s_axi_rresp_out <= 2'b00;
        case (s_axi_araddr_in)
          `PTA_CTRL_OFF: s_axi_rdata_out <= ctrl_reg;
          `PTA_STAT_OFF: s_axi_rdata_out <= {20'h0, fsdi_reg, cid_reg, 1'b0, 3'(state_reg)};
          `PTA_ATS_OFF: s_axi_rdata_out <= ats_reg;
          `PTA_HIST_OFF: s_axi_rdata_out <= hist_reg;
          default: begin
            s_axi_rdata_out <= 32'h0;
            s_axi_rresp_out <= 2'b10;
          end
        endcase
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out <= 1'b0;
      end
    end
  end

  // a RATS seen outside the selected step never starts an ATS
  a_rats_once: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    $rose(state_reg == PTA_ATS_SEND) |-> $past(state_reg == PTA_SELECTED && is_rats))
    else $error("ATS started outside selected step");
  a_cid_latch: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    state_reg == PTA_SELECTED && is_rats && ctrl_reg[0] && !sel_done_in && !field_reset_in
    |=> cid_reg == $past(rx_b1_reg[3:0]))
    else $error("identifier not taken from RATS");
  a_bad_crc: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    rx_eof_in && !rx_crc_ok_in && !sel_done_in |=> $stable(cid_reg))
    else $error("identifier changed on bad frame");
  a_fmt_bit8: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tx_valid_out && state_reg == PTA_ATS_SEND && tx_idx_reg == 5'd1 |-> !tx_byte_out[7])
    else $error("format byte bit8 set");
  a_pps_echo: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tx_valid_out && state_reg == PTA_PPS_SEND |-> tx_byte_out[7:4] == `PTA_PPS_NIB)
    else $error("PPS response not a start byte");
  // an offered answer byte stays put until the transmitter takes it
  a_tx_hold: assert property (@(posedge clk_sys_in) disable iff (rst_in)
    tx_valid_out && !tx_ready_in && (state_reg == PTA_ATS_SEND || state_reg == PTA_PPS_SEND)
    |=> tx_valid_out && $stable(tx_byte_out) && $stable(tx_last_out))
    else $error("answer byte dropped before taken");
endmodule // pta_activation
`default_nettype wire

//--- pta_activation_test.sv
// Purpose: self-checking bench for the type A activation block
// Assumes: register bus spoken by the bench, link side by the reader model
// Notes: waits are bounded; a hang ends at the cycle ceiling
`timescale 1ns/1ns
`default_nettype none
`include "pta_regs.svh"
module pta_activation_test;
  import pta_pkg::*;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic sel_done = 1'b0;
  logic field_reset = 1'b0;
  logic slow = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, rxv, rxe, rxc, txr, txv, txl, act;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [7:0] rxb, txb;
  logic [3:0] cid;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  always #50 clk_sys_in = ~clk_sys_in;
  pta_activation pta_activation_i (.clk_sys_in(clk_sys_in), .rst_in(rst_in),
    .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
    .s_axi_wdata_in(wdata), .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid),
    .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
    .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
    .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
    .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .sel_done_in(sel_done),
    .field_reset_in(field_reset), .rx_valid_in(rxv), .rx_byte_in(rxb), .rx_eof_in(rxe),
    .rx_crc_ok_in(rxc), .tx_ready_in(txr), .tx_valid_out(txv), .tx_byte_out(txb),
    .tx_last_out(txl), .cid_out(cid), .active_out(act));
  pta_pcd_model pta_pcd_model_i (.clk_sys_in(clk_sys_in), .slow_in(slow), .tx_valid_in(txv),
    .tx_byte_in(txb), .tx_last_in(txl), .rx_valid_out(rxv), .rx_byte_out(rxb),
    .rx_eof_out(rxe), .rx_crc_ok_out(rxc), .tx_ready_out(txr));
  // value compare, four-state so an unknown matches only an unknown
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // each channel released at the edge that takes it
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge clk_sys_in);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (awready)
        awvalid <= 1'b0;
      if (wready)
        wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    @(posedge clk_sys_in);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk_sys_in);
      if (arready)
        arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk(rdata, ed);
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  // one-cycle pulses from the layer below
  task automatic pulse(input logic fr, input logic sd);
    @(posedge clk_sys_in);
    field_reset <= fr;
    sel_done <= sd;
    @(posedge clk_sys_in);
    field_reset <= 1'b0;
    sel_done <= 1'b0;
  endtask
  // send a frame, then expect the answer bytes (none: silence for the whole window)
  task automatic xfer(input logic [7:0] f[$], input logic ok, input logic [7:0] e[$]);
    int n0;
    n0 = pta_pcd_model_i.nfr;
    pta_pcd_model_i.got.delete();
    pta_pcd_model_i.send(f, ok);
    for (int i = 0; i < 300 && pta_pcd_model_i.nfr == n0; i++)
      @(posedge clk_sys_in);
    repeat (4) @(posedge clk_sys_in);
    chk(32'(pta_pcd_model_i.got.size()), 32'(e.size()));
    foreach (e[i])
      chk({24'h0, pta_pcd_model_i.got[i]}, {24'h0, e[i]});
  endtask
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // cycle ceiling; the tests need about 2300 cycles
  always @(posedge clk_sys_in) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      give_verdict();
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys_in);
    rst_in <= 1'b0;
    repeat (2) @(posedge clk_sys_in);
    axi_rd(`PTA_CTRL_OFF, `PTA_CTRL_RST, 2'b00);
    axi_rd(`PTA_ATS_OFF, `PTA_ATS_RST, 2'b00);
    axi_rd(8'h10, 32'h0, 2'b10);
    axi_wr(8'h10, 32'h0, 2'b10);
    axi_wr(`PTA_HIST_OFF, 32'h4433_2211, 2'b00);
    axi_wr(`PTA_CTRL_OFF, 32'h1, 2'b00);
    // default ats, broken crc first, then a good rats, then a further rats that must be ignored
    pulse(1'b0, 1'b1);
    xfer('{`PTA_RATS_CODE, 8'h57}, 1'b0, '{});
    chk({28'h0, cid}, 32'h0);
    slow <= 1'b1;
    xfer('{`PTA_RATS_CODE, 8'h57}, 1'b1,
      '{8'h06, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44});
    chk({31'h0, act}, 32'h1);
    axi_rd(`PTA_STAT_OFF, {20'h0, 4'h5, 4'h7, 1'b0, PTA_ACTIVE}, 2'b00);
    xfer('{`PTA_RATS_CODE, 8'h52}, 1'b1, '{});
    chk({28'h0, cid}, 32'h7);
    // another block before the rats spoils the rats window
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    xfer('{8'h02, 8'h00}, 1'b1, '{});
    xfer('{`PTA_RATS_CODE, 8'h57}, 1'b1, '{});
    // all interface bytes present, pps accepted once
    slow <= 1'b0;
    axi_wr(`PTA_CTRL_OFF, 32'h3, 2'b00);
    axi_wr(`PTA_ATS_OFF, 32'h0280_9172, 2'b00);
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    xfer('{`PTA_RATS_CODE, 8'h83}, 1'b1,
      '{8'h09, 8'h72, 8'h91, 8'h80, 8'h02, 8'h11, 8'h22, 8'h33, 8'h44});
    chk({31'h0, act}, 32'h1);
    // sfgi is zero here, so the reader sends at once
    xfer('{8'hd3, 8'h11, 8'h05}, 1'b1, '{8'hd3});
    axi_rd(`PTA_STAT_OFF, {20'h0, 4'h8, 4'h3, 1'b0, PTA_ACTIVE}, 2'b00);
    xfer('{8'hd3, 8'h11, 8'h05}, 1'b1, '{});
    // a halt right after selection parks the card; a later RATS gets nothing
    pulse(1'b1, 1'b0);
    pulse(1'b0, 1'b1);
    xfer('{`PTA_HALT_CODE, 8'h00}, 1'b1, '{});
    xfer('{`PTA_RATS_CODE, 8'h41}, 1'b1, '{});
    chk({31'h0, act}, 32'h0);
    axi_rd(`PTA_STAT_OFF, {20'h0, 4'h8, 4'h3, 1'b0, PTA_HALTED}, 2'b00);
    give_verdict();
  end
endmodule // pta_activation_test
`default_nettype wire

//--- pta_pcd_model.sv
// Purpose: reader-side model that sends frames to the card block and collects its answers
// Assumes: crc is checked below the card block and arrives as a flag with end of frame
// Notes: byte and crc lines that are not in use carry the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module pta_pcd_model (
  input wire logic clk_sys_in,
  input wire logic slow_in, // stall the card transmitter every other cycle
  input wire logic tx_valid_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic tx_last_in,
  output logic rx_valid_out,
  output logic [7:0] rx_byte_out,
  output logic rx_eof_out,
  output logic rx_crc_ok_out,
  output logic tx_ready_out
);
  logic [7:0] got[$]; // bytes taken from the card
  int nfr = 0; // frames the card has finished
  initial begin
    rx_valid_out = 1'b0;
    rx_byte_out = 8'h00;
    rx_eof_out = 1'b0;
    rx_crc_ok_out = 1'b0;
    tx_ready_out = 1'b0;
  end
  // one byte per strobe with a gap; a stale byte would hide a late sample
  task automatic send(input logic [7:0] b[$], input logic crc_good);
    foreach (b[i]) begin
      @(posedge clk_sys_in);
      rx_valid_out <= 1'b1;
      rx_byte_out <= b[i];
      @(posedge clk_sys_in);
      rx_valid_out <= 1'b0;
      rx_byte_out <= ~b[i];
    end
    @(posedge clk_sys_in);
    rx_eof_out <= 1'b1;
    rx_crc_ok_out <= crc_good;
    @(posedge clk_sys_in);
    rx_eof_out <= 1'b0;
    rx_crc_ok_out <= ~crc_good;
  endtask
  // take answer bytes, promptly or with stalls
  always @(posedge clk_sys_in) begin
    tx_ready_out <= slow_in ? ~tx_ready_out : 1'b1;
    if (tx_valid_in && tx_ready_out) begin
      got.push_back(tx_byte_in);
      if (tx_last_in)
        nfr = nfr + 1;
    end
  end
endmodule // pta_pcd_model
`default_nettype wire

//--- pta_pkg.sv
// Purpose: types for the type A activation block
// Assumes: nothing
// Notes: state of the activation sequence
package pta_pkg;
  typedef enum logic [2:0] {
    PTA_IDLE,
    PTA_SELECTED,
    PTA_ATS_SEND,
    PTA_PPS_WAIT,
    PTA_PPS_SEND,
    PTA_ACTIVE,
    PTA_HALTED
  } pta_state_t;
endpackage

//--- pta_regs.svh
// Purpose: constants for the type A activation block (register map, frame codes, field layout)
// Assumes: included by its bare name
// Notes: definitions only
`ifndef PTA_REGS_SVH
`define PTA_REGS_SVH
// register byte offsets
`define PTA_CTRL_OFF 8'h00
`define PTA_STAT_OFF 8'h04
`define PTA_ATS_OFF 8'h08
`define PTA_HIST_OFF 8'h0c
// reset values
`define PTA_CTRL_RST 32'h0000_0000
`define PTA_ATS_RST 32'h0040_0002
// frame codes
`define PTA_RATS_CODE 8'he0
`define PTA_PPS_NIB 4'hd
`define PTA_HALT_CODE 8'h50
`define PTA_CID_RFU 4'hf
// frame size codes
`define PTA_FSCI_DEF 4'h2
`define PTA_FSI_MAX 4'h8
// format byte presence bits
`define PTA_T0_TA 4
`define PTA_T0_TB 5
`define PTA_T0_TC 6
`endif
